// >>> core/fvr_core.sv
// Purpose: command sequencer for block/section blank check, one-time read, phrase program
// Assumes: Avalon-MM slave with waitrequest, array port answers with a one-cycle ack
// Notes: one wait state on every bus access; array accesses are 16-bit words
`timescale 1ns/1ps
`default_nettype none
`include "fvr_defs.svh"

module fvr_core #(
    parameter logic [23:0] PF_LO = `FVR_PF_LO,
    parameter logic [23:0] PF_HI = `FVR_PF_HI,
    parameter logic [23:0] EE_LO = `FVR_EE_LO,
    parameter logic [23:0] EE_HI = `FVR_EE_HI,
    parameter logic [23:0] ONCE_BASE = `FVR_ONCE_BASE
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // register bus
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // flash array port
    output fvr_pkg::fvr_fl_req_t o_fl,
    input wire fvr_pkg::fvr_fl_rsp_t i_fl,
    // status
    output logic o_cmd_complete,
    output logic o_pflash_rd_invalid
);
    fvr_pkg::fvr_st_t s_q;
    fvr_pkg::fvr_st_t s_d;

    // ------------------------------------------------------------
    // decoded command fields
    // ------------------------------------------------------------
    logic [7:0] code;
    logic [23:0] gaddr;
    logic [24:0] sec_end;
    logic in_pf;
    logic in_ee;
    logic misal;
    logic prot_hit;

    // parameter words split into command and address
    assign code = s_q.prm[0][15:8];
    assign gaddr = {s_q.prm[0][7:0], s_q.prm[1]};
    // last byte of the section; the extra bit catches a wrap
    assign sec_end = {1'b0, gaddr} + {6'h00, s_q.prm[2], 3'h0} - 25'h0000001;
    // which flash block the address falls in
    assign in_pf = (gaddr >= PF_LO) && (gaddr <= PF_HI);
    assign in_ee = (gaddr >= EE_LO) && (gaddr <= EE_HI);
    // phrase alignment and protected area of the target
    assign misal = gaddr[2:0] != 3'h0;
    assign prot_hit = s_q.prot_en && (gaddr[17:0] >= s_q.prot_lo);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // idle: wait for a launch write
    // check: all launch-time tests in one cycle
    // read: blank check or one-time fetch, word by word
    // prog: four word writes to the phrase
    // verify: read the phrase back and compare
    // done: raise the complete flag, back to idle
    // hazard: bus writes and the sequencer share s_d;
    // the sequencer assigns last, so its sets win
    // over a same-cycle clear from the bus
    always_comb begin
        logic req;
        logic acc_w;
        logic bad;
        logic [31:0] rv;
        logic [2:0] wsel;
        logic err_any;
        logic err_nc;
        req = 1'b0;
        acc_w = 1'b0;
        bad = 1'b0;
        rv = 32'h00000000;
        wsel = 3'h0;
        err_any = 1'b0;
        err_nc = 1'b0;
        s_d = s_q;

        // one wait state, then the access completes
        req = i_avs_read | i_avs_write;
        // ack toggles so each request sees one wait cycle
        s_d.ack = req & ~s_q.ack;
        // a write counts only in its second cycle
        acc_w = i_avs_write & s_q.ack;

        // read data captured during the wait state
        unique case (i_avs_address)
            `FVR_OFF_STAT: begin
                rv[`FVR_B_CMD_COMPLETE_FLAG] = s_q.cmd_complete_flag;
                rv[`FVR_B_ACC] = s_q.acc;
                rv[`FVR_B_PV] = s_q.pviol;
                rv[`FVR_B_MG1] = s_q.mg1;
                rv[`FVR_B_MG0] = s_q.mg0;
            end
            // index reads back in the low bits
            `FVR_OFF_IDX: rv[2:0] = s_q.idx;
            `FVR_OFF_PRM: begin
                // words past the last read as zero
                if (s_q.idx <= 3'h5) begin
                    rv[15:0] = s_q.prm[s_q.idx];
                end
            end
            `FVR_OFF_DIV: begin
                rv[`FVR_B_DIVOK] = s_q.div_ok;
                rv[6:0] = s_q.div;
            end
            `FVR_OFF_PROT: begin
                rv[`FVR_B_PROTEN] = s_q.prot_en;
                rv[17:0] = s_q.prot_lo;
            end
            `FVR_OFF_MODE: rv[0] = s_q.perm;
            default: rv = 32'h00000000;
        endcase
        if (i_avs_read && !s_q.ack) begin
            // first cycle of a read loads the data flop
            s_d.rdata = rv;
        end

        // register writes; flag clears come before any hardware set below
        if (acc_w) begin
            unique case (i_avs_address)
                `FVR_OFF_STAT: begin
                    if (i_avs_writedata[`FVR_B_ACC]) begin
                        s_d.acc = 1'b0;
                    end
                    if (i_avs_writedata[`FVR_B_PV]) begin
                        s_d.pviol = 1'b0;
                    end
                    // launch only from idle with no pending error
                    if (i_avs_writedata[`FVR_B_CMD_COMPLETE_FLAG] && s_q.cmd_complete_flag && !s_d.acc && !s_d.pviol) begin
                        s_d.cmd_complete_flag = 1'b0;
                        s_d.mg1 = 1'b0;
                        s_d.mg0 = 1'b0;
                        s_d.fsm = fvr_pkg::FVR_CHECK;
                    end
                end
                `FVR_OFF_IDX: begin
                    if (s_q.cmd_complete_flag) begin
                        // index only moves while idle
                        s_d.idx = i_avs_writedata[2:0];
                    end
                end
                `FVR_OFF_PRM: begin
                    if (s_q.cmd_complete_flag && s_q.idx <= 3'h5) begin
                        // bus writes to the parameters are blocked while a command runs
                        s_d.prm[s_q.idx] = i_avs_writedata[15:0];
                    end
                end
                `FVR_OFF_DIV: begin
                    if (s_q.cmd_complete_flag) begin
                        s_d.div = i_avs_writedata[6:0];
                        // any write while idle marks the divider as loaded
                        s_d.div_ok = 1'b1;
                    end
                end
                `FVR_OFF_PROT: begin
                    if (s_q.cmd_complete_flag) begin
                        // enable bit and lower bound of the area
                        s_d.prot_en = i_avs_writedata[`FVR_B_PROTEN];
                        s_d.prot_lo = i_avs_writedata[17:0];
                    end
                end
                `FVR_OFF_MODE: begin
                    if (s_q.cmd_complete_flag) begin
                        // one bit opens the restricted commands
                        s_d.perm = i_avs_writedata[0];
                    end
                end
                default: s_d.cmd_complete_flag = s_q.cmd_complete_flag;
            endcase
        end

        // array answer classification
        err_any = i_fl.corr | i_fl.uncorr;
        err_nc = i_fl.uncorr;
        // parameter word paired with the current array word
        wsel = {1'b0, s_q.wptr} + 3'h2;

        // command sequencer
        unique case (s_q.fsm)
            // nothing runs; the field marker stays low
            fvr_pkg::FVR_IDLE: begin
                s_d.info = 1'b0;
            end
            // every launch test decided in this one cycle
            fvr_pkg::FVR_CHECK: begin
                s_d.wptr = 2'h0;
                s_d.info = 1'b0;
                s_d.addr = gaddr;
                unique case (code)
                    // whole block, from its first word
                    `FVR_CMD_VBLK: begin
                        bad = (s_q.idx != `FVR_IX_VBLK) || !(in_pf || in_ee);
                        if (in_pf) begin
                            s_d.addr = PF_LO;
                            s_d.left = 19'((PF_HI - PF_LO + 24'h000001) >> 1);
                        end else begin
                            s_d.addr = EE_LO;
                            s_d.left = 19'((EE_HI - EE_LO + 24'h000001) >> 1);
                        end
                        s_d.fsm = fvr_pkg::FVR_READ;
                    end
                    // section given as first phrase and count
                    `FVR_CMD_VSEC: begin
                        bad = (s_q.idx != `FVR_IX_VSEC) || !s_q.perm || !in_pf || misal;
                        bad = bad || (sec_end > {1'b0, PF_HI});
                        // four words per phrase
                        s_d.left = {1'b0, s_q.prm[2], 2'h0};
                        s_d.fsm = (s_q.prm[2] == 16'h0000) ? fvr_pkg::FVR_DONE
                                                           : fvr_pkg::FVR_READ;
                    end
                    // one phrase of the information field
                    `FVR_CMD_RONCE: begin
                        bad = (s_q.idx != `FVR_IX_RONCE) || !s_q.perm;
                        bad = bad || (s_q.prm[1] > `FVR_ONCE_MAX);
                        // eight phrases of eight bytes each
                        s_d.addr = ONCE_BASE + 24'({s_q.prm[1][4:0], 3'h0});
                        s_d.info = 1'b1;
                        s_d.left = 19'h00004;
                        s_d.fsm = fvr_pkg::FVR_READ;
                    end
                    // protection looked at only once access checks pass
                    `FVR_CMD_PROG: begin
                        bad = (s_q.idx != `FVR_IX_PROG) || !s_q.perm || !in_pf || misal;
                        bad = bad || !s_q.div_ok;
                        if (!bad && prot_hit) begin
                            s_d.pviol = 1'b1;
                            s_d.fsm = fvr_pkg::FVR_DONE;
                        end else begin
                            s_d.fsm = fvr_pkg::FVR_PROG;
                        end
                        s_d.left = 19'h00004;
                    end
                    default: bad = 1'b1;
                endcase
                if (bad) begin
                    s_d.acc = 1'b1;
                    s_d.fsm = fvr_pkg::FVR_DONE;
                end
            end
            // waits for the array; one word per ack
            fvr_pkg::FVR_READ: begin
                if (i_fl.ack) begin
                    // blank check or one-time fetch, by command
                    if (code == `FVR_CMD_RONCE) begin
                        s_d.prm[wsel] = i_fl.rdata;
                    end else if (i_fl.rdata != `FVR_ERASED) begin
                        s_d.mg1 = 1'b1;
                        s_d.mg0 = 1'b1;
                    end
                    s_d.mg1 = s_d.mg1 | err_any;
                    s_d.mg0 = s_d.mg0 | err_nc;
                    s_d.addr = s_q.addr + 24'h000002;
                    s_d.left = s_q.left - 19'h00001;
                    s_d.wptr = s_q.wptr + 2'h1;
                    if (s_q.left == 19'h00001) begin
                        s_d.fsm = fvr_pkg::FVR_DONE;
                    end
                end
            end
            // write phase, data from parameter words 2 to 5
            fvr_pkg::FVR_PROG: begin
                if (i_fl.ack) begin
                    s_d.addr = s_q.addr + 24'h000002;
                    s_d.left = s_q.left - 19'h00001;
                    s_d.wptr = s_q.wptr + 2'h1;
                    // all four words written: read the phrase back
                    if (s_q.left == 19'h00001) begin
                        s_d.addr = gaddr;
                        s_d.left = 19'h00004;
                        s_d.fsm = fvr_pkg::FVR_VERIFY;
                    end
                end
            end
            // readback phase of a program
            fvr_pkg::FVR_VERIFY: begin
                if (i_fl.ack) begin
                    // a word that reads back wrong cannot be corrected
                    if (i_fl.rdata != s_q.prm[wsel]) begin
                        s_d.mg1 = 1'b1;
                        s_d.mg0 = 1'b1;
                    end
                    s_d.mg1 = s_d.mg1 | err_any;
                    s_d.mg0 = s_d.mg0 | err_nc;
                    s_d.addr = s_q.addr + 24'h000002;
                    s_d.left = s_q.left - 19'h00001;
                    s_d.wptr = s_q.wptr + 2'h1;
                    if (s_q.left == 19'h00001) begin
                        s_d.fsm = fvr_pkg::FVR_DONE;
                    end
                end
            end
            // one cycle to finish before the flag rises
            fvr_pkg::FVR_DONE: begin
                s_d.cmd_complete_flag = 1'b1;
                s_d.info = 1'b0;
                s_d.fsm = fvr_pkg::FVR_IDLE;
            end
            default: s_d.fsm = fvr_pkg::FVR_IDLE;
        endcase

        // write data follows the word pointer of the next cycle
        s_d.wd = s_d.prm[{1'b0, s_d.wptr} + 3'h2];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            // complete set, protection bound at top, mode open
            s_q <= '0;
            s_q.fsm <= fvr_pkg::FVR_IDLE;
            s_q.cmd_complete_flag <= 1'b1;
            s_q.prot_lo <= `FVR_RST_PROT;
            s_q.perm <= `FVR_RST_PERM;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // bus answer
    // wait state ends once the ack flop is set
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s_q.ack;
    assign o_avs_readdata = s_q.rdata;

    // array request held until ack
    assign o_fl.req = (s_q.fsm == fvr_pkg::FVR_READ) || (s_q.fsm == fvr_pkg::FVR_PROG) ||
                      (s_q.fsm == fvr_pkg::FVR_VERIFY);
    // write strobe only in the program phase
    assign o_fl.wr = s_q.fsm == fvr_pkg::FVR_PROG;
    assign o_fl.info = s_q.info;
    assign o_fl.addr = s_q.addr;
    assign o_fl.wdata = s_q.wd;

    // status levels
    assign o_cmd_complete = s_q.cmd_complete_flag;
    // program flash reads are not served while a one-time read runs
    assign o_pflash_rd_invalid = !s_q.cmd_complete_flag && (code == `FVR_CMD_RONCE);
endmodule
`default_nettype wire

// >>> pkg/fvr_defs.svh
// Purpose: constants of the flash verify/read/program sequencer
// Assumes: byte addresses on the register bus, one 32-bit word each
// Notes: definitions only
`ifndef FVR_DEFS_SVH
`define FVR_DEFS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define FVR_OFF_STAT 5'h00
`define FVR_OFF_IDX 5'h04
`define FVR_OFF_PRM 5'h08
`define FVR_OFF_DIV 5'h0c
`define FVR_OFF_PROT 5'h10
`define FVR_OFF_MODE 5'h14
// ------------------------------------------------------------
// register bit positions and reset values
// ------------------------------------------------------------
`define FVR_B_CMD_COMPLETE_FLAG 7
`define FVR_B_ACC 5
`define FVR_B_PV 4
`define FVR_B_MG1 1
`define FVR_B_MG0 0
`define FVR_B_DIVOK 7
`define FVR_B_PROTEN 31
`define FVR_RST_PROT 18'h3ffff
`define FVR_RST_PERM 1'h1
// ------------------------------------------------------------
// commands, final indices, array figures
// ------------------------------------------------------------
`define FVR_CMD_VBLK 8'h02
`define FVR_CMD_VSEC 8'h03
`define FVR_CMD_RONCE 8'h04
`define FVR_CMD_PROG 8'h06
`define FVR_IX_VBLK 3'h1
`define FVR_IX_VSEC 3'h2
`define FVR_IX_RONCE 3'h1
`define FVR_IX_PROG 3'h5
`define FVR_ONCE_MAX 16'h0007
`define FVR_ERASED 16'hffff
`define FVR_PF_LO 24'hfc0000
`define FVR_PF_HI 24'hffffff
`define FVR_EE_LO 24'h100000
`define FVR_EE_HI 24'h1007ff
`define FVR_ONCE_BASE 24'h000000
`endif

// >>> pkg/fvr_pkg.sv
// Purpose: types of the flash verify/read/program sequencer
// Assumes: fvr_defs.svh holds the numbers
// Notes: state of the core is one packed struct
package fvr_pkg;
    typedef enum logic [2:0] {
        FVR_IDLE = 3'b000,
        FVR_CHECK = 3'b001,
        FVR_READ = 3'b010,
        FVR_PROG = 3'b011,
        FVR_VERIFY = 3'b100,
        FVR_DONE = 3'b101
    } fvr_state_t;

    // request to the array
    typedef struct packed {
        logic req;
        logic wr;
        logic info;
        logic [23:0] addr;
        logic [15:0] wdata;
    } fvr_fl_req_t;

    // answer from the array
    typedef struct packed {
        logic ack;
        logic corr;
        logic uncorr;
        logic [15:0] rdata;
    } fvr_fl_rsp_t;

    typedef struct packed {
        fvr_state_t fsm;
        logic cmd_complete_flag;
        logic acc;
        logic pviol;
        logic mg1;
        logic mg0;
        logic [2:0] idx;
        logic [5:0][15:0] prm;
        logic div_ok;
        logic [6:0] div;
        logic prot_en;
        logic [17:0] prot_lo;
        logic perm;
        logic ack;
        logic [31:0] rdata;
        logic [23:0] addr;
        logic [18:0] left;
        logic [1:0] wptr;
        logic info;
        logic [15:0] wd;
    } fvr_st_t;
endpackage

// >>> verif/fvr_core_asserts.sv
// Purpose: port-level checks of the flash sequencer
// Assumes: launch written as b0 to status, clearing error flags
// Notes: bound into fvr_core below
`timescale 1ns/1ps
`default_nettype none
`include "fvr_defs.svh"
module fvr_core_asserts (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // register bus
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // array port and status
    input wire fvr_pkg::fvr_fl_req_t o_fl,
    input wire fvr_pkg::fvr_fl_rsp_t i_fl,
    input wire logic o_cmd_complete,
    input wire logic o_pflash_rd_invalid
);
    logic launch;
    logic [2:0] wacks_q;
    logic [2:0] wacks_d;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // --------------------
    // helper: launch and write-ack count
    // --------------------
    assign launch = i_avs_write && !o_avs_waitrequest && o_cmd_complete
        && i_avs_address == `FVR_OFF_STAT && i_avs_writedata[7:4] == 4'hb;
    always_comb begin
        wacks_d = wacks_q;
        if (launch) wacks_d = 3'h0;
        else if (o_fl.req && o_fl.wr && i_fl.ack) wacks_d = wacks_q + 3'h1;
    end
    always_ff @(posedge i_clk_sys) begin
        wacks_q <= i_sys_rst ? 3'h0 : wacks_d;
    end
    sequence s_launch;
        launch;
    endsequence
    sequence s_one_wait;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    // --------------------
    // properties
    // --------------------
    AST_LAUNCH_CLEARS: assert property (s_launch |=> !o_cmd_complete)
        else $error("complete flag did not fall at launch");
    AST_BUSY_ARRAY: assert property (o_fl.req |-> !o_cmd_complete)
        else $error("array busy while complete");
    AST_CHECK_FIRST: assert property (s_launch |=> !o_fl.req && !o_cmd_complete)
        else $error("array touched before checks");
    AST_RESET_IDLE: assert property ($fell(i_sys_rst) |-> o_cmd_complete && !o_fl.req)
        else $error("not idle after reset");
    AST_BUS_WAIT: assert property ($rose(i_avs_read || i_avs_write) |-> s_one_wait)
        else $error("bus wait state wrong");
    AST_HOLD_REQ: assert property (o_fl.req && !i_fl.ack |=> o_fl.req
        && $stable(o_fl.addr) && $stable(o_fl.wr) && $stable(o_fl.wdata))
        else $error("array request changed before ack");
    AST_WORD_STEP: assert property (o_fl.req && i_fl.ack && o_fl.addr[2:1] != 2'h3
        ##1 o_fl.req |-> o_fl.addr == $past(o_fl.addr) + 24'h2)
        else $error("phrase words not consecutive");
    AST_FOUR_WRITES: assert property ($fell(o_fl.wr) |-> wacks_q == 3'h4
        ##[0:3] (o_fl.req && !o_fl.wr))
        else $error("program not four words then readback");
    AST_ONCE_FIELD: assert property (o_fl.req && o_fl.info |-> !o_fl.wr
        && o_fl.addr < 24'h40 && o_pflash_rd_invalid)
        else $error("one-time access out of field");
    AST_INVALID_BUSY: assert property (o_pflash_rd_invalid |-> !o_cmd_complete)
        else $error("read-invalid while idle");
endmodule
bind fvr_core fvr_core_asserts u_chk (.i_clk_sys, .i_sys_rst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .o_fl, .i_fl, .o_cmd_complete, .o_pflash_rd_invalid);
`default_nettype wire

// >>> verif/fvr_flash_mdl.sv
// Purpose: behavioural flash array behind the sequencer
// Assumes: 16-bit words keyed by info bit and byte address
// Notes: erased reads ffff; idle read data toggles so stale use shows
`timescale 1ns/1ps
`default_nettype none
`include "fvr_defs.svh"
module fvr_flash_mdl (
    // clock
    input wire logic i_clk,
    // array port
    input wire fvr_pkg::fvr_fl_req_t i_fl,
    output fvr_pkg::fvr_fl_rsp_t o_fl,
    // stall and ecc injection
    input wire logic i_slow,
    input wire logic [1:0] i_ecc
);
    logic [15:0] mem [logic [24:0]];
    int cnt = 0;
    function automatic logic [15:0] get(input logic [24:0] a);
        return mem.exists(a) ? mem[a] : `FVR_ERASED;
    endfunction
    // --------------------
    // one ack per word
    // --------------------
    initial o_fl = '0;
    always @(posedge i_clk) begin
        o_fl.ack <= 1'b0;
        o_fl.corr <= 1'b0;
        o_fl.uncorr <= 1'b0;
        o_fl.rdata <= ~o_fl.rdata; // no valid data between answers
        if (i_fl.req && !o_fl.ack && cnt >= (i_slow ? 3 : 0)) begin
            cnt <= 0;
            o_fl.ack <= 1'b1;
            o_fl.corr <= i_ecc[0] && !i_fl.wr;
            o_fl.uncorr <= i_ecc[1] && !i_fl.wr;
            if (i_fl.wr) mem[{i_fl.info, i_fl.addr}] = i_fl.wdata;
            else o_fl.rdata <= get({i_fl.info, i_fl.addr});
        end else begin
            cnt <= i_fl.req ? cnt + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: register-level tests of the flash sequencer
// Assumes: program flash shrunk to ffff00..ffffff
// Notes: each command checked through the status register
`timescale 1ns/1ps
`default_nettype none
`include "fvr_defs.svh"
module tb;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [4:0] adr = '0;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wd = '0;
    logic [31:0] rdat;
    logic wreq;
    logic cmpl;
    logic inval;
    logic slow = 1'b0;
    logic [1:0] ecc = 2'h0;
    logic inv_seen = 1'b0;
    fvr_pkg::fvr_fl_req_t fl_req;
    fvr_pkg::fvr_fl_rsp_t fl_rsp;
    logic [15:0] pw [6];
    logic [31:0] q;
    int num_errors = 0;
    int n_checks = 0;
    // --------------------
    // clock, design and array
    // --------------------
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (inval) inv_seen <= 1'b1;
    fvr_core #(.PF_LO(24'hffff00)) DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q),
        .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .o_fl(fl_req), .i_fl(fl_rsp), .o_cmd_complete(cmpl), .o_pflash_rd_invalid(inval));
    fvr_flash_mdl mdl (.i_clk(i_clk_sys), .i_fl(fl_req), .o_fl(fl_rsp), .i_slow(slow),
        .i_ecc(ecc));
    // --------------------
    // tasks
    // --------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic mchk(input logic [24:0] a, input logic [15:0] e);
        chk({16'h0, mdl.get(a)}, {16'h0, e});
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        adr <= a;
        wd <= d;
        wr_q <= w;
        rd_q <= !w;
        do @(posedge i_clk_sys); while (wreq !== 1'b0);
        q = rdat;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    // load n words, set final index, launch, wait, check status
    task automatic run(input int n, input logic [2:0] ix, input logic [31:0] exp);
        int t;
        for (int i = 0; i < n; i++) begin
            bus(1'b1, `FVR_OFF_IDX, 32'(i));
            bus(1'b1, `FVR_OFF_PRM, {16'h0, pw[i]});
        end
        bus(1'b1, `FVR_OFF_IDX, {29'h0, ix});
        bus(1'b1, `FVR_OFF_STAT, 32'h30);
        bus(1'b1, `FVR_OFF_STAT, 32'hb0);
        t = 0;
        do begin
            @(posedge i_clk_sys);
            t++;
        end while (cmpl !== 1'b1 && t < 9000);
        if (t >= 9000) num_errors++;
        bus(1'b0, `FVR_OFF_STAT, 32'h0);
        chk(q, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // --------------------
    // watchdog and tests
    // --------------------
    initial begin
        #400000;
        num_errors++;
        conclude();
    end
    initial begin
        for (int k = 0; k < 4; k++) mdl.mem[{1'b1, 24'h38 + 24'(2 * k)}] = 16'ha000 + 16'(k);
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        bus(1'b0, `FVR_OFF_STAT, 32'h0);
        chk(q, 32'h80);
        bus(1'b0, `FVR_OFF_PROT, 32'h0);
        chk(q, 32'h3ffff);
        bus(1'b0, `FVR_OFF_MODE, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, 5'h18, 32'h0);
        chk(q, 32'h0);
        $display("reset test done");
        pw = '{16'h06ff, 16'hff08, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        run(6, 3'h5, 32'ha0);
        mchk(25'h0ffff08, 16'hffff);
        pw[0] = 16'h02ff;
        pw[1] = 16'hff00;
        run(2, 3'h1, 32'h80);
        run(2, 3'h2, 32'ha0);
        pw[0] = 16'h0210;
        pw[1] = 16'h0000;
        slow <= 1'b1;
        run(2, 3'h1, 32'h80);
        slow <= 1'b0;
        pw[0] = 16'h0220;
        run(2, 3'h1, 32'ha0);
        pw[0] = 16'h05ff;
        run(2, 3'h1, 32'ha0);
        $display("block test done");
        bus(1'b1, `FVR_OFF_DIV, 32'h0f);
        pw = '{16'h06ff, 16'hff08, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        run(6, 3'h4, 32'ha0);
        run(6, 3'h5, 32'h80);
        for (int k = 0; k < 4; k++) mchk(25'h0ffff08 + 25'(2 * k), 16'h1111 * 16'(k + 1));
        pw[1] = 16'hff12;
        run(6, 3'h5, 32'ha0);
        mchk(25'h0ffff12, 16'hffff);
        pw[0] = 16'h02ff;
        pw[1] = 16'hff00;
        run(2, 3'h1, 32'h83);
        $display("program test done");
        pw = '{16'h03ff, 16'hff10, 16'h0004, 16'h0, 16'h0, 16'h0};
        run(3, 3'h2, 32'h80);
        pw[1] = 16'hff08;
        pw[2] = 16'h0001;
        run(3, 3'h2, 32'h83);
        pw[1] = 16'hffe0;
        pw[2] = 16'h0005;
        run(3, 3'h2, 32'ha0);
        pw[2] = 16'h0004;
        run(3, 3'h2, 32'h80);
        $display("section test done");
        bus(1'b1, `FVR_OFF_PROT, 32'h8003ff40);
        pw = '{16'h06ff, 16'hff40, 16'h5555, 16'h6666, 16'h7777, 16'h8888};
        run(6, 3'h5, 32'h90);
        mchk(25'h0ffff40, 16'hffff);
        pw[0] = 16'h02ff;
        pw[1] = 16'hff00;
        run(2, 3'h1, 32'h83);
        bus(1'b1, `FVR_OFF_PROT, 32'h0003ffff);
        pw = '{16'h06ff, 16'hff40, 16'h5555, 16'h6666, 16'h7777, 16'h8888};
        ecc <= 2'h1;
        run(6, 3'h5, 32'h82);
        $display("protect test done");
        pw[0] = 16'h0400;
        pw[1] = 16'h0007;
        ecc <= 2'h0;
        chk({31'h0, inv_seen}, 32'h0);
        run(2, 3'h1, 32'h80);
        chk({31'h0, inv_seen}, 32'h1);
        for (int i = 2; i < 6; i++) begin
            bus(1'b1, `FVR_OFF_IDX, 32'(i));
            bus(1'b0, `FVR_OFF_PRM, 32'h0);
            chk(q, 32'ha000 + 32'(i - 2));
        end
        ecc <= 2'h1;
        run(2, 3'h1, 32'h82);
        ecc <= 2'h2;
        run(2, 3'h1, 32'h83);
        ecc <= 2'h0;
        run(2, 3'h2, 32'ha0);
        pw[1] = 16'h0008;
        run(2, 3'h1, 32'ha0);
        $display("once test done");
        bus(1'b1, `FVR_OFF_MODE, 32'h0);
        pw[1] = 16'h0000;
        run(2, 3'h1, 32'ha0);
        pw = '{16'h03ff, 16'hff10, 16'h0001, 16'h0, 16'h0, 16'h0};
        run(3, 3'h2, 32'ha0);
        bus(1'b1, `FVR_OFF_MODE, 32'h1);
        $display("mode test done");
        conclude();
    end
endmodule
`default_nettype wire
